/* core/cpf_pkg.sv */
// Contract
// - a fault starts its oscillator-timed counter with its own fixed delay
// - timer expiry with fault still present drops the matching gate enable
// - release runs a recovery timer; recurrence aborts it, expiry re-enables
// - overcharge delay is one of 0.25, 1.00, 1.25, 4.50 s; drops charge
// - over-discharge delay is one of 20, 96, 125, 144 ms
// - over-discharge expiry drives the discharge gate enable high to low
// - discharge overcurrent delay is one of 8, 16, 20, 48 ms; drops discharge
// - charge overcurrent delay is one of 4, 6, 8, 16 ms
// - charge overcurrent expiry drives the charge gate enable high to low
// - short circuit delay is fixed 250 us; drops discharge
// - in normal mode both gate enables are high
// - zero-volt charging of a depleted cell only while charger exceeds 1.7 V
// - charge gate goes high once the charger reaches zero-volt start
// - charge gate goes low while the cell is below zero-volt inhibit
// - thresholds and delay choices are build-time constants, never runtime
// - short circuit threshold is one of 300, 400, 500, 600 mV
// - charge overcurrent is ignored while in the over-discharge state
package cpf_pkg;

  // clock and timer base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 10000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_US = TICK_PERIOD_NS / 1000;
  localparam int DIV_W = 7;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;

  // factory delay choices in microseconds
  localparam int OVP_DELAY_TABLE_US [4] = '{250000, 1000000, 1250000, 4500000};
  localparam int UVP_DELAY_TABLE_US [4] = '{20000, 96000, 125000, 144000};
  localparam int OCD_DELAY_TABLE_US [4] = '{8000, 16000, 20000, 48000};
  localparam int OCC_DELAY_TABLE_US [4] = '{4000, 6000, 8000, 16000};
  localparam int SCC_DELAY_US = 250;
  localparam int RECOVER_DELAY_US = 1000;

  // channel order in the fault vectors
  localparam int NUM_CH = 5;
  localparam int CH_OVP = 0;
  localparam int CH_UVP = 1;
  localparam int CH_OCD = 2;
  localparam int CH_OCC = 3;
  localparam int CH_SCC = 4;

  // threshold code widths and top codes (code 0 is the lowest magnitude)
  localparam int OVP_CODE_W = 4;
  localparam int UVP_CODE_W = 5;
  localparam int OC_CODE_W = 5;
  localparam int SCC_CODE_W = 2;
  localparam int OVP_CODE_MAX = 15;
  localparam int UVP_CODE_MAX = 16;
  localparam int OC_CODE_MAX = 22;

  // per-channel timer state
  typedef enum logic [1:0] {
    CPF_IDLE,
    CPF_DETECT,
    CPF_TRIPPED,
    CPF_RECOVER
  } cpf_state_e;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    cpf_state_e st;
    logic [CNT_W-1:0] cnt;
    logic tripped;
  } cpf_ch_s;

endpackage

/* core/cpf_fault_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module cpf_fault_channel import cpf_pkg::*; #(
  parameter int DELAY_TICKS = 25,
  parameter int RECOVER_TICKS = 100
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic fault_async,
  input wire logic enable,
  output logic fault_level,
  output logic tripped
);

  localparam logic [CNT_W-1:0] DELAY_CNT = CNT_W'(DELAY_TICKS);
  localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(RECOVER_TICKS);
  localparam cpf_ch_s CH_RESET = '{sync: 3'h0, level: 1'b0, st: CPF_IDLE,
                                   cnt: '0, tripped: 1'b0};

  cpf_ch_s r;
  cpf_ch_s next_r;
  logic active;

  //////////////////////////////////////////////////////////////////////////
  // sync, filter and timer state machine
  always_comb begin
    next_r = r;
    next_r.sync = {r.sync[1:0], fault_async};
    // only the agreeing later stages may move the level, first flop unread
    if (r.sync[1] == r.sync[2]) begin
      next_r.level = r.sync[2];
    end
    active = r.level & enable;
    case (r.st)
      CPF_IDLE: begin
        next_r.cnt = '0;
        if (active) begin
          next_r.st = CPF_DETECT;
        end
      end
      CPF_DETECT: begin
        if (!active) begin
          next_r.st = CPF_IDLE;
          next_r.cnt = '0;
        end else if (tick) begin
          // one extra tick so the delay is never shorter than nominal
          if (r.cnt == DELAY_CNT) begin
            next_r.st = CPF_TRIPPED;
            next_r.tripped = 1'b1;
            next_r.cnt = '0;
          end else begin
            next_r.cnt = r.cnt + CNT_ONE;
          end
        end
      end
      CPF_TRIPPED: begin
        next_r.cnt = '0;
        if (!active) begin
          next_r.st = CPF_RECOVER;
        end
      end
      CPF_RECOVER: begin
        if (active) begin
          next_r.st = CPF_TRIPPED;
          next_r.cnt = '0;
        end else if (tick) begin
          if (r.cnt == RECOVER_CNT) begin
            next_r.st = CPF_IDLE;
            next_r.tripped = 1'b0;
            next_r.cnt = '0;
          end else begin
            next_r.cnt = r.cnt + CNT_ONE;
          end
        end
      end
      default: begin
        next_r = CH_RESET;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= CH_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign fault_level = r.level;
  assign tripped = r.tripped;

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_level_agree: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.level != $past(r.level)) |-> ($past(r.sync[1]) == $past(r.sync[2])))
    else $error("level moved without agreeing sync stages");

  chk_detect_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.st == CPF_IDLE && active) |=> (r.st == CPF_DETECT && r.cnt == '0))
    else $error("fault did not start a fresh detection timer");

  chk_detect_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.st == CPF_DETECT && !active) |=> (r.st == CPF_IDLE && r.cnt == '0))
    else $error("detection timer not cleared on fault drop");

  chk_trip_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(r.tripped) |-> ($past(active) && $past(tick)
                          && $past(r.cnt) == DELAY_CNT))
    else $error("trip without full delay on a present fault");

  chk_recover_abort: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.st == CPF_RECOVER && active) |=> (r.st == CPF_TRIPPED && r.tripped))
    else $error("recurring fault did not abort recovery");

  chk_recover_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.st == CPF_TRIPPED && !active) |=> (r.st == CPF_RECOVER && r.tripped))
    else $error("released fault did not start recovery");

endmodule // cpf_fault_channel
`default_nettype wire

/* core/cpf_protector.sv */
`timescale 1ns/10ps
`default_nettype none
module cpf_protector import cpf_pkg::*; #(
  parameter logic [1:0] OVP_SEL = 2'h0,
  parameter logic [1:0] UVP_SEL = 2'h0,
  parameter logic [1:0] OCD_SEL = 2'h0,
  parameter logic [1:0] OCC_SEL = 2'h0,
  parameter int OVP_DELAY_US = OVP_DELAY_TABLE_US[OVP_SEL],
  parameter int UVP_DELAY_US = UVP_DELAY_TABLE_US[UVP_SEL],
  parameter int OCD_DELAY_US = OCD_DELAY_TABLE_US[OCD_SEL],
  parameter int OCC_DELAY_US = OCC_DELAY_TABLE_US[OCC_SEL],
  parameter int REC_DELAY_US = RECOVER_DELAY_US,
  parameter logic [OVP_CODE_W-1:0] OVP_THR_CODE = 4'h0,
  parameter logic [UVP_CODE_W-1:0] UVP_THR_CODE = 5'h00,
  parameter logic [OC_CODE_W-1:0] OCD_THR_CODE = 5'h00,
  parameter logic [OC_CODE_W-1:0] OCC_THR_CODE = 5'h00,
  parameter logic [SCC_CODE_W-1:0] SCC_THR_CODE = 2'h0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic overcharge_fault,
  input wire logic overdischarge_fault,
  input wire logic discharge_overcurrent_fault,
  input wire logic charge_overcurrent_fault,
  input wire logic short_circuit_fault,
  input wire logic zero_volt_charge_start,
  input wire logic zero_volt_charge_inhibit,
  output logic charge_gate_enable,
  output logic discharge_gate_enable,
  output logic [NUM_CH-1:0] fault_tripped,
  output logic [OVP_CODE_W-1:0] overcharge_threshold_code,
  output logic [UVP_CODE_W-1:0] overdischarge_threshold_code,
  output logic [OC_CODE_W-1:0] discharge_overcurrent_threshold_code,
  output logic [OC_CODE_W-1:0] charge_overcurrent_threshold_code,
  output logic [SCC_CODE_W-1:0] short_circuit_threshold_code
);

  //////////////////////////////////////////////////////////////////////////
  // delay figures turned into timer ticks, rounded up
  // a coarser tick would save counter bits, but the fixed short-circuit
  // delay would then stretch by a larger share of its nominal length
  localparam int DELAY_US [NUM_CH] = '{OVP_DELAY_US, UVP_DELAY_US,
                                       OCD_DELAY_US, OCC_DELAY_US,
                                       SCC_DELAY_US};
  localparam int REC_TICKS = (REC_DELAY_US + TICK_US - 1) / TICK_US;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  // whole top state in one record
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic [2:0] start_sync;
    logic start_level;
    logic [2:0] inhibit_sync;
    logic inhibit_level;
    logic chg;
    logic dsg;
    logic [NUM_CH-1:0] trip;
    logic [OVP_CODE_W-1:0] ovp_code;
    logic [UVP_CODE_W-1:0] uvp_code;
    logic [OC_CODE_W-1:0] ocd_code;
    logic [OC_CODE_W-1:0] occ_code;
    logic [SCC_CODE_W-1:0] scc_code;
  } cpf_top_s;

  localparam cpf_top_s TOP_RESET = '{div: '0, tick: 1'b0, start_sync: 3'h0,
    start_level: 1'b0, inhibit_sync: 3'h0, inhibit_level: 1'b0,
    chg: 1'b0, dsg: 1'b0, trip: '0, ovp_code: OVP_THR_CODE,
    uvp_code: UVP_THR_CODE, ocd_code: OCD_THR_CODE,
    occ_code: OCC_THR_CODE, scc_code: SCC_THR_CODE};

  cpf_top_s r;
  cpf_top_s next_r;
  logic [NUM_CH-1:0] fault_in;
  logic [NUM_CH-1:0] ch_enable;
  logic [NUM_CH-1:0] ch_level;
  logic [NUM_CH-1:0] ch_trip;

  assign fault_in[CH_OVP] = overcharge_fault;
  assign fault_in[CH_UVP] = overdischarge_fault;
  assign fault_in[CH_OCD] = discharge_overcurrent_fault;
  assign fault_in[CH_OCC] = charge_overcurrent_fault;
  assign fault_in[CH_SCC] = short_circuit_fault;

  //////////////////////////////////////////////////////////////////////////
  // one timer channel per fault comparator
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // charge overcurrent is masked once the cell is in over-discharge
      if (gi == CH_OCC) begin : g_occ_en
        assign ch_enable[gi] = ~ch_trip[CH_UVP];
      end else begin : g_en
        assign ch_enable[gi] = 1'b1;
      end
      cpf_fault_channel #(
        .DELAY_TICKS((DELAY_US[gi] + TICK_US - 1) / TICK_US),
        .RECOVER_TICKS(REC_TICKS)
      ) u_ch (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(r.tick),
        .fault_async(fault_in[gi]),
        .enable(ch_enable[gi]),
        .fault_level(ch_level[gi]),
        .tripped(ch_trip[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // tick divider, zero-volt syncs and gate decisions
  always_comb begin
    next_r = r;
    // one-cycle timer tick every TICK_CYCLES oscillator cycles
    // the tick is registered so every channel counts on the same edge
    if (r.div == DIV_LAST) begin
      next_r.div = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + DIV_ONE;
      next_r.tick = 1'b0;
    end
    next_r.start_sync = {r.start_sync[1:0], zero_volt_charge_start};
    next_r.inhibit_sync = {r.inhibit_sync[1:0], zero_volt_charge_inhibit};
    if (r.start_sync[1] == r.start_sync[2]) begin
      next_r.start_level = r.start_sync[2];
    end
    if (r.inhibit_sync[1] == r.inhibit_sync[2]) begin
      next_r.inhibit_level = r.inhibit_sync[2];
    end
    next_r.trip = ch_trip;
    // gates come from registers, so a comparator glitch can never reach
    // a pin without passing the filters first, and fault inputs the timers too
    // discharge path: over-discharge, discharge overcurrent or short circuit drop it
    next_r.dsg = ~(ch_trip[CH_UVP] | ch_trip[CH_OCD]
                   | ch_trip[CH_SCC]);
    // charge path: inhibit beats everything, zero-volt beats overcurrent
    if (r.inhibit_level) begin
      next_r.chg = 1'b0;
    end else if (ch_trip[CH_UVP]) begin
      next_r.chg = r.start_level;
    end else begin
      next_r.chg = ~(ch_trip[CH_OVP] | ch_trip[CH_OCC]);
    end
    // factory codes come only from parameters, no runtime path writes them
    next_r.ovp_code = OVP_THR_CODE;
    next_r.uvp_code = UVP_THR_CODE;
    next_r.ocd_code = OCD_THR_CODE;
    next_r.occ_code = OCC_THR_CODE;
    next_r.scc_code = SCC_THR_CODE;
  end

  // state register; gates stay off during reset as the safe state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= TOP_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign charge_gate_enable = r.chg;
  assign discharge_gate_enable = r.dsg;
  assign fault_tripped = r.trip;
  assign overcharge_threshold_code = r.ovp_code;
  assign overdischarge_threshold_code = r.uvp_code;
  assign discharge_overcurrent_threshold_code = r.ocd_code;
  assign charge_overcurrent_threshold_code = r.occ_code;
  assign short_circuit_threshold_code = r.scc_code;

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_chg_inhibit: assert property (
    @(posedge clk_sys) disable iff (rst)
    r.inhibit_level |=> !charge_gate_enable)
    else $error("charge gate high while inhibit level set");

  chk_chg_zero_volt: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ch_trip[CH_UVP] && !r.inhibit_level)
      |=> (charge_gate_enable == $past(r.start_level)))
    else $error("depleted cell charge gate not following charger level");

  chk_chg_fault_off: assert property (
    @(posedge clk_sys) disable iff (rst)
    ((ch_trip[CH_OVP] || ch_trip[CH_OCC]) && !ch_trip[CH_UVP])
      |=> !charge_gate_enable)
    else $error("charge gate high with overcharge or charge overcurrent");

  chk_dsg_fault_off: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ch_trip[CH_UVP] || ch_trip[CH_OCD] || ch_trip[CH_SCC])
      |=> !discharge_gate_enable)
    else $error("discharge gate high with a discharge fault tripped");

  chk_normal_both_on: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ch_trip == '0 && !r.inhibit_level)
      |=> (charge_gate_enable && discharge_gate_enable))
    else $error("gates not both on in normal mode");

  chk_occ_masked: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ch_trip[CH_UVP] && !ch_trip[CH_OCC]) |=> !$rose(ch_trip[CH_OCC]))
    else $error("charge overcurrent tripped during over-discharge");

  chk_tick_period: assert property (
    @(posedge clk_sys) disable iff (rst)
    r.tick |=> !r.tick [*8])
    else $error("timer tick faster than its divider");

  chk_cfg_stable: assert property (
    @(posedge clk_sys) disable iff (rst)
    $stable(r.ovp_code) && $stable(r.uvp_code) && $stable(r.scc_code)
      && $stable(r.ocd_code) && $stable(r.occ_code))
    else $error("factory configuration code changed at runtime");

  chk_cfg_range: assert property (
    @(posedge clk_sys) disable iff (rst)
    (int'(OCD_THR_CODE) <= OC_CODE_MAX && int'(OCC_THR_CODE) <= OC_CODE_MAX
     && int'(OVP_THR_CODE) <= OVP_CODE_MAX
     && int'(UVP_THR_CODE) <= UVP_CODE_MAX))
    else $error("threshold code outside its factory range");


  //////////////////////////////////////////////////////////////////////////
  // divider and output bookkeeping checks
  // the divider must never skip or stall, or every delay stretches silently
  chk_div_range: assert property (
    @(posedge clk_sys) disable iff (rst)
    r.div <= DIV_LAST)
    else $error("tick divider ran past its last count");

  chk_div_step: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.div != DIV_LAST) |=> (r.div == $past(r.div) + DIV_ONE))
    else $error("tick divider did not advance by one");

  // a tick is issued exactly on the wrap of the divider
  chk_tick_wrap: assert property (
    @(posedge clk_sys) disable iff (rst)
    r.tick |-> (r.div == '0 && $past(r.div) == DIV_LAST))
    else $error("timer tick not aligned with the divider wrap");

  // status bits mirror the channel flags one register later
  chk_trip_mirror: assert property (
    @(posedge clk_sys) disable iff (rst)
    fault_tripped == $past(ch_trip))
    else $error("tripped status does not follow the channels");

  // a new trip needs the synchronised fault level in the cycle before
  chk_trip_on_level: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ch_trip & ~$past(ch_trip) & ~$past(ch_level)) == '0)
    else $error("channel tripped without its fault level");

  // a gate only falls for a cause that the gate logic names
  chk_chg_fall_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(charge_gate_enable) |-> $past(r.inhibit_level || ch_trip[CH_OVP]
      || ch_trip[CH_OCC] || (ch_trip[CH_UVP] && !r.start_level)))
    else $error("charge gate dropped without a cause");

  chk_dsg_fall_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(discharge_gate_enable) |-> $past(ch_trip[CH_UVP]
      || ch_trip[CH_OCD] || ch_trip[CH_SCC]))
    else $error("discharge gate dropped without a cause");

  // once the matching faults have recovered the gate comes straight back
  chk_dsg_restore: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(ch_trip[CH_UVP] || ch_trip[CH_OCD] || ch_trip[CH_SCC])
      |=> discharge_gate_enable)
    else $error("discharge gate not restored after recovery");

  chk_chg_restore: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(r.inhibit_level || ch_trip[CH_UVP] || ch_trip[CH_OVP]
      || ch_trip[CH_OCC]) |=> charge_gate_enable)
    else $error("charge gate not restored after recovery");

  // a depleted cell with a charger present is allowed to charge
  chk_zv_start_on: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ch_trip[CH_UVP] && !r.inhibit_level && r.start_level)
      |=> charge_gate_enable)
    else $error("charger present but depleted cell not charged");

  // the zero-volt levels move only when both late sync stages agree
  chk_start_agree: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.start_level != $past(r.start_level))
      |-> ($past(r.start_sync[1]) == $past(r.start_sync[2])))
    else $error("start level moved without agreeing sync stages");

  chk_inhibit_agree: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.inhibit_level != $past(r.inhibit_level))
      |-> ($past(r.inhibit_sync[1]) == $past(r.inhibit_sync[2])))
    else $error("inhibit level moved without agreeing sync stages");

endmodule // cpf_protector
`default_nettype wire

/* testbench/cpf_fet_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cpf_fet_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic charge_gate_enable,
  input wire logic discharge_gate_enable,
  output logic charge_path_on,
  output logic discharge_path_on
);
  // fets follow their gates one clock late; gate charging is far quicker
  // than any fault delay, so one cycle models it without hiding a glitch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      charge_path_on <= 1'b0;
      discharge_path_on <= 1'b0;
    end else begin
      charge_path_on <= charge_gate_enable;
      discharge_path_on <= discharge_gate_enable;
    end
  end
endmodule // cpf_fet_model
`default_nettype wire

/* testbench/cpf_protector_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cpf_protector_test;
  import cpf_pkg::*;
  localparam int REC_T = 5;
  localparam int DLY_T [NUM_CH] = '{10, 5, 5, 5, 25};
  localparam logic GATE_DSG [NUM_CH] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic clk_sys, rst, zv_start, zv_inhibit, chg, dsg, chg_on, dsg_on;
  logic [NUM_CH-1:0] flt, tripped;
  logic [20:0] codes;
  logic [16:0] rnd;
  int error_cnt, checked, cycles, n;

  //////////////////////////////////////////////////////////////////////////
  // shortened delays keep the run small; expectations use the same ticks;
  // trim codes keep their factory default of code 0
  cpf_protector #(.OVP_DELAY_US(100), .UVP_DELAY_US(50), .OCD_DELAY_US(50),
    .OCC_DELAY_US(50), .REC_DELAY_US(50)) i_dut (
    .clk_sys(clk_sys), .rst(rst),
    .overcharge_fault(flt[CH_OVP]), .overdischarge_fault(flt[CH_UVP]),
    .discharge_overcurrent_fault(flt[CH_OCD]),
    .charge_overcurrent_fault(flt[CH_OCC]),
    .short_circuit_fault(flt[CH_SCC]),
    .zero_volt_charge_start(zv_start), .zero_volt_charge_inhibit(zv_inhibit),
    .charge_gate_enable(chg), .discharge_gate_enable(dsg),
    .fault_tripped(tripped), .overcharge_threshold_code(codes[20:17]),
    .overdischarge_threshold_code(codes[16:12]),
    .discharge_overcurrent_threshold_code(codes[11:7]),
    .charge_overcurrent_threshold_code(codes[6:2]),
    .short_circuit_threshold_code(codes[1:0]));
  cpf_fet_model i_fets (.clk_sys(clk_sys), .rst(rst),
    .charge_gate_enable(chg), .discharge_gate_enable(dsg),
    .charge_path_on(chg_on), .discharge_path_on(dsg_on));

  //////////////////////////////////////////////////////////////////////////
  // clock and a hang guard well above the ~16k cycles the tests need
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 40000) begin
      error_cnt++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // a trip lands one tick window after the full count, plus sync and regs
  function automatic bit in_win(input int cnt, input int t);
    return (cnt >= t * 100 + 2) && (cnt <= (t + 1) * 100 + 10);
  endfunction
  function automatic logic gate_of(input int ch);
    return GATE_DSG[ch] ? dsg : chg;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // counts falling edges until the channel's gate shows val, bounded
  task automatic wait_gate(input int ch, input logic val, output int cnt);
    cnt = 0;
    while (gate_of(ch) !== val && cnt < 4000) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence, inputs move on falling edges only
  initial begin
    rst = 1'b1;
    flt = '0;
    zv_start = 1'b1;
    zv_inhibit = 1'b0;
    rnd = 17'h100bd;
    repeat (6) @(negedge clk_sys);
    check({chg, dsg, tripped}, 7'h00, "gates in reset");
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    check({chg, dsg}, 2'b11, "normal gates");
    check(codes, {4'h0, 5'h00, 5'h00, 5'h00, 2'h0}, "trim codes");
    // every channel: early drop, full trip, release and recovery
    for (int ch = 0; ch < NUM_CH; ch++) begin
      rnd = lfsr(rnd);
      flt[ch] = 1'b1;
      repeat (20 + rnd[7:0]) @(negedge clk_sys);
      flt[ch] = 1'b0;
      repeat (8) @(negedge clk_sys);
      check(gate_of(ch), 1'b1, "early drop");
      flt[ch] = 1'b1;
      wait_gate(ch, 1'b0, n);
      check(in_win(n, DLY_T[ch]), 1'b1, "trip delay");
      check(in_win(n, DLY_T[ch]), 1'b1, "trip delay");
      check(tripped, 32'h1 << ch, "tripped bit");
      check(GATE_DSG[ch] ? chg : dsg, 1'b1, "other gate");
      flt[ch] = 1'b0;
      wait_gate(ch, 1'b1, n);
      check(in_win(n, REC_T), 1'b1, "recovery delay");
      check(tripped, 5'h00, "tripped cleared");
    end
    // recurrence during recovery keeps the gate off and restarts recovery
    flt[CH_OCD] = 1'b1;
    wait_gate(CH_OCD, 1'b0, n);
    flt[CH_OCD] = 1'b0;
    repeat (200) @(negedge clk_sys);
    flt[CH_OCD] = 1'b1;
    repeat (REC_T * 100 + 200) @(negedge clk_sys);
    check({dsg, tripped}, 6'h04, "recurrence");
    flt[CH_OCD] = 1'b0;
    wait_gate(CH_OCD, 1'b1, n);
    check(in_win(n, REC_T), 1'b1, "recovery restart");
    // single-sample glitch must never reach the timers
    flt[CH_SCC] = 1'b1;
    @(negedge clk_sys);
    flt[CH_SCC] = 1'b0;
    repeat (2800) @(negedge clk_sys);
    check({dsg, tripped}, 6'h20, "glitch filtered");
    // depleted cell: charge gate follows the charger flag, ignores occ
    flt[CH_UVP] = 1'b1;
    wait_gate(CH_UVP, 1'b0, n);
    zv_start = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(chg, 1'b0, "no charger");
    flt[CH_OCC] = 1'b1;
    zv_start = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(chg, 1'b1, "zero volt start");
    repeat (700) @(negedge clk_sys);
    check({chg, tripped[CH_OCC]}, 2'b10, "occ ignored");
    zv_inhibit = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(chg, 1'b0, "inhibit");
    zv_inhibit = 1'b0;
    flt[CH_OCC] = 1'b0;
    flt[CH_UVP] = 1'b0;
    wait_gate(CH_UVP, 1'b1, n);
    repeat (4) @(negedge clk_sys);
    check({chg_on, dsg_on}, 2'b11, "fets back on");
    final_report();
  end
endmodule // cpf_protector_test
`default_nettype wire
